// *** common/wdit_pkg.sv ***
// Purpose: Shared constants for the watchdog and interval timer.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes: Feed byte values and timing counts are implementation constants.
package wdit_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PRESC_W = 12;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned TAP_W = 3;
    localparam int unsigned TAP_BASE = 4;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_FEED = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_AUX = 8'h18;

    // Control register fields.
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_RSTEN_BIT = 1;
    localparam int unsigned CTRL_CLKSEL_BIT = 2;
    localparam int unsigned CTRL_TAP_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status and mask fields.
    localparam int unsigned STAT_TMO_BIT = 0;
    localparam int unsigned STAT_WDRST_BIT = 1;
    localparam int unsigned STAT_W = 2;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [1:0] IRQ_SRC_MASK = 2'h1;

    localparam int unsigned AUX_SWRST_BIT = 0;

    localparam logic [CNT_W-1:0] RELOAD_RESET = 8'hFF;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 12'h000;

    // Two-byte feed sequence.
    localparam logic [7:0] FEED_FIRST = 8'hA5;
    localparam logic [7:0] FEED_SECOND = 8'h5A;

    // Clock select: 0 is the peripheral clock, 1 the watchdog oscillator.
    localparam logic CLKSEL_PCLK = 1'b0;
    localparam logic CLKSEL_WDOSC = 1'b1;

    // Timing.
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned WDOSC_NOMINAL_HZ = 400_000;
    localparam int unsigned RST_HOLD_NS = 1000;
    localparam int unsigned SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int unsigned RST_HOLD_CYC =
        (RST_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W = 6;

    typedef enum logic [1:0] {
        WDIT_FEED_IDLE,
        WDIT_FEED_ARMED,
        WDIT_FEED_CTRL
    } wdit_feed_t;
endpackage : wdit_pkg

// *** dv/wdit_properties.sv ***
// Purpose: Port-level checks for the watchdog and interval timer.
// Assumes: Zero-wait APB; feed state is mirrored from observed writes.
// Notes: Only sequences the bench keeps well-formed are mirrored exactly.
`timescale 1ns/10ps
module wdit_properties (
    input wire logic sys_clk,
    input wire logic soft_reset_request,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdit_pkg::ADDR_W-1:0] paddr,
    input wire logic [wdit_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [wdit_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdosc_clk_pin,
    input wire logic power_down,
    input wire logic sys_reset_req,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (soft_reset_request);
    logic wr, fd, armed_q, ctrl_q, sel_q, feed_err, ctrl_err;
    logic [7:0] b0;
    logic [5:0] hold_q;
    assign wr = psel & penable & pwrite;
    assign b0 = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign fd = paddr == wdit_pkg::OFS_FEED;
    assign feed_err = wr & !ctrl_q & (armed_q ?
        !(fd && b0 == wdit_pkg::FEED_SECOND) : (fd && b0 != wdit_pkg::FEED_FIRST));
    assign ctrl_err = wr & ctrl_q & !(fd && b0 == wdit_pkg::FEED_FIRST);
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            armed_q <= 1'b0;
            ctrl_q <= 1'b0;
        end else if (wr) begin
            armed_q <= fd & (b0 == wdit_pkg::FEED_FIRST) & !armed_q;
            ctrl_q <= paddr == wdit_pkg::OFS_CTRL;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            sel_q <= wdit_pkg::CLKSEL_PCLK;
        end else if (wr && paddr == wdit_pkg::OFS_CTRL) begin
            sel_q <= b0[wdit_pkg::CTRL_CLKSEL_BIT];
        end
    end
    // Saturates so a long retriggered hold cannot wrap to a small count.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request || !sys_reset_req) begin
            hold_q <= 6'h00;
        end else begin
            hold_q <= hold_q + 6'(hold_q != 6'h3F);
        end
    end
    soft_reset_request_clear_a: assert property ($fell(soft_reset_request) |-> !sys_reset_req && !irq)
        else $error("outputs not clear after power-on reset");
    feed_err_a: assert property (feed_err |=> sys_reset_req)
        else $error("malformed feed gave no reset");
    ctrl_nofeed_a: assert property (ctrl_err |=> sys_reset_req)
        else $error("control write without feed gave no reset");
    sw_reset_a: assert property (wr && paddr == wdit_pkg::OFS_AUX && b0[0]
        |=> sys_reset_req) else $error("software reset not raised");
    rst_hold_a: assert property ($fell(sys_reset_req) && !$past(soft_reset_request)
        |-> hold_q >= wdit_pkg::RST_HOLD_CYC) else $error("reset pulse short");
    pd_quiet_a: assert property (power_down && $past(power_down) && !wr &&
        sel_q == wdit_pkg::CLKSEL_PCLK && !sys_reset_req |=> !sys_reset_req)
        else $error("reset raised in power-down");
    irq_mask_a: assert property (wr && paddr == wdit_pkg::OFS_MASK && !b0[0]
        |=> !irq) else $error("masked interrupt still high");
    upper_zero_a: assert property (psel && penable && !pwrite
        |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule : wdit_properties

// *** dv/wdit_test.sv ***
// Purpose: Self-checking bench for the watchdog and interval timer.
// Assumes: Peripheral clock with tap 0 gives 32 cycles per count step.
// Notes: Timeout windows allow a few cycles of pipeline slack.
`timescale 1ns/10ps
module wdit_test;
    logic sys_clk = 1'b0;
    logic soft_reset_request = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sys_reset_req, irq, slv;
    logic wdosc_clk_pin = 1'b0;
    logic power_down = 1'b0;
    logic [4:0] oc = 5'h00;
    logic [7:0] r;
    int errors = 0;
    int n_compared = 0;
    int c;
    logic [39:0] rst_tab [5] = '{40'h00_00000000, 40'h04_000000FF,
        40'h08_000000FF, 40'h10_00000000, 40'h14_00000000};
    logic [32:0] seq_tab [5] = '{33'h0_0CA5_0C5B, 33'h0_0CA5_0407,
        33'h0_0000_0407, 33'h0_0407_0C11, 33'h1_0CA5_0C5A};
    wdit_top DUT (.sys_clk(sys_clk), .soft_reset_request(soft_reset_request), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdosc_clk_pin(wdosc_clk_pin), .power_down(power_down),
        .sys_reset_req(sys_reset_req), .irq(irq));
    initial forever #25 sys_clk = ~sys_clk;
    // Oscillator pin at 400 kHz: one toggle every 25 system cycles.
    always @(posedge sys_clk) begin
        oc <= (oc == 5'd24) ? 5'd0 : oc + 5'd1;
        if (oc == 5'd24) wdosc_clk_pin <= ~wdosc_clk_pin;
    end
    function automatic int tmo(input logic [7:0] v);
        return 32 * (int'(v) + 1);
    endfunction : tmo
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench watchdog may end a wait that never completes.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic feed();
        apb(1, wdit_pkg::OFS_FEED, 32'hA5);
        apb(1, wdit_pkg::OFS_FEED, 32'h5A);
    endtask : feed
    task automatic lvl(input logic v, input int lim);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (sys_reset_req !== v && c < lim);
    endtask : lvl
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (90000) @(posedge sys_clk);
        errors++;
        $display("Error at %0t: run did not finish", $time);
        tally_and_finish();
    end
    initial begin
        c = $urandom(32'hD5A1);
        repeat (12) @(posedge sys_clk);
        soft_reset_request <= 1'b0;
        foreach (rst_tab[i]) begin
            apb(0, rst_tab[i][39:32], 32'h0);
            cmp(rd, rst_tab[i][31:0]);
        end
        apb(0, 8'h1C, 32'h0);
        cmp(rd, 32'h0);
        cmp(32'(slv), 32'h1);
        $display("Test reset values done");
        r = 8'($urandom_range(15, 4));
        apb(1, wdit_pkg::OFS_RELOAD, 32'(r));
        apb(1, wdit_pkg::OFS_CTRL, 32'h3);
        feed();
        repeat (3) begin
            lvl(1, 16 * int'(r));
            cmp(sys_reset_req, 1'b0);
            feed();
        end
        lvl(1, tmo(r) + 40);
        cmp(c >= tmo(r) - 4 && c <= tmo(r) + 8, 1'b1);
        apb(0, wdit_pkg::OFS_STATUS, 32'h0);
        cmp(rd[1], 1'b1);
        apb(0, wdit_pkg::OFS_RELOAD, 32'h0);
        cmp(rd, 32'(r));
        apb(1, wdit_pkg::OFS_CTRL, 32'h0);
        feed();
        $display("Test watchdog timeout done");
        foreach (seq_tab[i]) begin
            lvl(0, 60);
            apb(1, seq_tab[i][31:24], 32'(seq_tab[i][23:16]));
            apb(1, seq_tab[i][15:8], 32'(seq_tab[i][7:0]));
            @(negedge sys_clk);
            cmp(sys_reset_req, !seq_tab[i][32]);
        end
        $display("Test feed sequences done");
        lvl(0, 60);
        // Three of the sequences above overwrite the reload value.
        apb(1, wdit_pkg::OFS_RELOAD, 32'(r));
        apb(1, wdit_pkg::OFS_MASK, 32'h1);
        apb(1, wdit_pkg::OFS_STATUS, 32'h3);
        apb(1, wdit_pkg::OFS_CTRL, 32'h1);
        feed();
        repeat (tmo(r) + 20) @(negedge sys_clk);
        cmp({sys_reset_req, irq}, 2'b01);
        apb(0, wdit_pkg::OFS_STATUS, 32'h0);
        cmp(rd, 32'h1);
        apb(1, wdit_pkg::OFS_STATUS, 32'h1);
        @(negedge sys_clk);
        cmp(irq, 1'b0);
        apb(1, wdit_pkg::OFS_MASK, 32'h0);
        $display("Test interval timer done");
        apb(1, wdit_pkg::OFS_CTRL, 32'h3);
        feed();
        @(posedge sys_clk);
        power_down <= 1'b1;
        lvl(1, tmo(r) + 60);
        cmp(sys_reset_req, 1'b0);
        apb(1, wdit_pkg::OFS_CTRL, 32'h7);
        feed();
        lvl(1, tmo(r) * 50 + 300);
        cmp(sys_reset_req, 1'b1);
        @(posedge sys_clk);
        power_down <= 1'b0;
        $display("Test power-down and oscillator done");
        apb(1, wdit_pkg::OFS_CTRL, 32'h44);
        feed();
        lvl(0, 60);
        apb(1, wdit_pkg::OFS_AUX, 32'h1);
        @(negedge sys_clk);
        cmp(sys_reset_req, 1'b1);
        apb(0, wdit_pkg::OFS_CTRL, 32'h0);
        cmp(rd, 32'h44);
        $display("Test software reset done");
        tally_and_finish();
    end
endmodule : wdit_test
bind wdit_top wdit_properties u_props (.sys_clk(sys_clk), .soft_reset_request(soft_reset_request),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdosc_clk_pin(wdosc_clk_pin),
    .power_down(power_down), .sys_reset_req(sys_reset_req), .irq(irq));

// *** src/wdit_prescaler.sv ***
// Purpose: 12-bit prescaler with a selectable output tap.
// Assumes: tick_en is a one-cycle enable at the selected watchdog clock rate.
// Notes: The tap pulse marks a roll-over of the low bits up to the tap.
`timescale 1ns/10ps
module wdit_prescaler (
    input wire logic sys_clk,
    input wire logic soft_reset_request,
    input wire logic clear,
    input wire logic tick_en,
    input wire logic [wdit_pkg::TAP_W-1:0] tap_sel,
    output logic tap_pulse
);
    logic [wdit_pkg::PRESC_W-1:0] presc_q;
    logic [wdit_pkg::PRESC_W-1:0] tap_mask;

    // The mask covers bits zero up to the selected tap position.
    function automatic logic [wdit_pkg::PRESC_W-1:0] tap_to_mask(
        input logic [wdit_pkg::TAP_W-1:0] sel
    );
        logic [wdit_pkg::PRESC_W-1:0] m;
        m = '0;
        for (int i = 0; i < wdit_pkg::PRESC_W; i++) begin
            if (i <= int'(sel) + wdit_pkg::TAP_BASE) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : tap_to_mask

    assign tap_mask = tap_to_mask(tap_sel);

    always_ff @(posedge sys_clk) begin
        if (soft_reset_request || clear) begin
            presc_q <= wdit_pkg::PRESC_RESET;
        end else if (tick_en) begin
            presc_q <= presc_q + 12'h001;
        end
    end

    // One pulse per wrap of the tapped bits sets the time-out period.
    assign tap_pulse = tick_en && !clear &&
        ((presc_q & tap_mask) == tap_mask);
endmodule : wdit_prescaler

// *** src/wdit_top.sv ***
// Purpose: Watchdog and interval timer with an APB register file.
// Assumes: soft_reset_request is the power-on reset; sys_reset_req goes to the chip reset.
// Notes: The watchdog oscillator arrives as a pin and is synchronised.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module wdit_top (
    input wire logic sys_clk,
    input wire logic soft_reset_request,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdit_pkg::ADDR_W-1:0] paddr,
    input wire logic [wdit_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [wdit_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdosc_clk_pin,
    input wire logic power_down,
    output logic sys_reset_req,
    output logic irq
);
    logic access;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [wdit_pkg::DATA_W-1:0] rd_mux;
    logic [7:0] wbyte;

    logic [7:0] ctrl_q;
    logic [wdit_pkg::CNT_W-1:0] reload_q;
    logic [wdit_pkg::CNT_W-1:0] count_q;
    logic [wdit_pkg::STAT_W-1:0] status_q;
    logic [wdit_pkg::STAT_W-1:0] mask_q;
    wdit_pkg::wdit_feed_t feed_q;
    logic [wdit_pkg::DATA_W-1:0] prdata_q;
    logic pslverr_q;

    logic wdosc_meta_q;
    logic wdosc_sync_q;
    logic wdosc_prev_q;
    logic wdosc_rise;

    logic run;
    logic rst_en;
    logic clk_sel;
    logic [wdit_pkg::TAP_W-1:0] tap_sel;
    logic tick_en;
    logic tap_pulse;
    logic halted;
    logic feed_done;
    logic feed_error;
    logic underflow;
    logic wd_reset_evt;
    logic sw_reset_evt;
    logic tmo_evt;
    logic [wdit_pkg::RST_CNT_W-1:0] rst_cnt_q;

    localparam logic [wdit_pkg::RST_CNT_W-1:0] RST_HOLD =
        wdit_pkg::RST_CNT_W'(wdit_pkg::RST_HOLD_CYC);

    function automatic logic hit(
        input logic [wdit_pkg::ADDR_W-1:0] a,
        input logic [7:0] ofs
    );
        return a == ofs;
    endfunction : hit

    // The bus answers in the access cycle; there are no wait states.
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign pready = 1'b1;
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

    assign addr_ok = hit(paddr, wdit_pkg::OFS_CTRL) ||
        hit(paddr, wdit_pkg::OFS_RELOAD) ||
        hit(paddr, wdit_pkg::OFS_COUNT) ||
        hit(paddr, wdit_pkg::OFS_FEED) ||
        hit(paddr, wdit_pkg::OFS_STATUS) ||
        hit(paddr, wdit_pkg::OFS_MASK) ||
        hit(paddr, wdit_pkg::OFS_AUX);

    assign run = ctrl_q[wdit_pkg::CTRL_RUN_BIT];
    assign rst_en = ctrl_q[wdit_pkg::CTRL_RSTEN_BIT];
    assign clk_sel = ctrl_q[wdit_pkg::CTRL_CLKSEL_BIT];
    assign tap_sel = ctrl_q[wdit_pkg::CTRL_TAP_LSB +: wdit_pkg::TAP_W];

    // Oscillator pin enters through two flip-flops before edge detection.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            wdosc_meta_q <= 1'b0;
            wdosc_sync_q <= 1'b0;
            wdosc_prev_q <= 1'b0;
        end else begin
            wdosc_meta_q <= wdosc_clk_pin;
            wdosc_sync_q <= wdosc_meta_q;
            wdosc_prev_q <= wdosc_sync_q;
        end
    end

    assign wdosc_rise = wdosc_sync_q && !wdosc_prev_q;

    // In power-down with the peripheral clock selected the chain freezes, so nothing can expire.
    assign halted = power_down && (clk_sel == wdit_pkg::CLKSEL_PCLK);
    assign tick_en = run && !halted &&
        ((clk_sel == wdit_pkg::CLKSEL_WDOSC) ? wdosc_rise : 1'b1);

    // Feed sequence checker. Reads may interleave; any other write breaks it.
    always_comb begin
        feed_done = 1'b0;
        feed_error = 1'b0;
        if (wr_en) begin
            unique case (feed_q)
                wdit_pkg::WDIT_FEED_IDLE: begin
                    if (hit(paddr, wdit_pkg::OFS_FEED) &&
                        wbyte != wdit_pkg::FEED_FIRST) begin
                        feed_error = 1'b1;
                    end
                end
                wdit_pkg::WDIT_FEED_CTRL: begin
                    if (!(hit(paddr, wdit_pkg::OFS_FEED) &&
                          wbyte == wdit_pkg::FEED_FIRST)) begin
                        feed_error = 1'b1;
                    end
                end
                wdit_pkg::WDIT_FEED_ARMED: begin
                    if (hit(paddr, wdit_pkg::OFS_FEED) &&
                        wbyte == wdit_pkg::FEED_SECOND) begin
                        feed_done = 1'b1;
                    end else begin
                        feed_error = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            feed_q <= wdit_pkg::WDIT_FEED_IDLE;
        end else if (wr_en) begin
            if (feed_error || feed_done) begin
                feed_q <= wdit_pkg::WDIT_FEED_IDLE;
            end else if (hit(paddr, wdit_pkg::OFS_CTRL)) begin
                feed_q <= wdit_pkg::WDIT_FEED_CTRL;
            end else if (hit(paddr, wdit_pkg::OFS_FEED)) begin
                feed_q <= wdit_pkg::WDIT_FEED_ARMED;
            end
        end
    end

    wdit_prescaler u_presc (
        .sys_clk(sys_clk),
        .soft_reset_request(soft_reset_request),
        .clear(feed_done),
        .tick_en(tick_en),
        .tap_sel(tap_sel),
        .tap_pulse(tap_pulse)
    );

    assign underflow = tap_pulse && (count_q == '0);
    assign tmo_evt = underflow && !rst_en;
    assign wd_reset_evt = (underflow && rst_en) || feed_error;
    assign sw_reset_evt = wr_en && hit(paddr, wdit_pkg::OFS_AUX) &&
        wbyte[wdit_pkg::AUX_SWRST_BIT];

    // Down counter reloads on a completed feed and after each underflow.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            count_q <= wdit_pkg::RELOAD_RESET;
        end else if (feed_done || underflow) begin
            count_q <= reload_q;
        end else if (tap_pulse) begin
            count_q <= count_q - 8'h01;
        end
    end

    // Only soft_reset_request clears these; the outgoing system reset does not loop back.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            ctrl_q <= wdit_pkg::CTRL_RESET;
        end else if (wr_en && hit(paddr, wdit_pkg::OFS_CTRL)) begin
            ctrl_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            reload_q <= wdit_pkg::RELOAD_RESET;
        end else if (wr_en && hit(paddr, wdit_pkg::OFS_RELOAD)) begin
            reload_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            mask_q <= wdit_pkg::MASK_RESET;
        end else if (wr_en && hit(paddr, wdit_pkg::OFS_MASK)) begin
            mask_q <= wbyte[wdit_pkg::STAT_W-1:0];
        end
    end

    // Write one to clear; a new event in the same cycle keeps the bit set.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            status_q <= wdit_pkg::STAT_RESET;
        end else begin
            if (wr_en && hit(paddr, wdit_pkg::OFS_STATUS)) begin
                status_q <= status_q & ~wbyte[wdit_pkg::STAT_W-1:0];
            end
            if (tmo_evt) begin
                status_q[wdit_pkg::STAT_TMO_BIT] <= 1'b1;
            end
            if (wd_reset_evt) begin
                status_q[wdit_pkg::STAT_WDRST_BIT] <= 1'b1;
            end
        end
    end

    // Only the time-out flag may interrupt; the reset cause bit is a record.
    assign irq = |(status_q & mask_q & wdit_pkg::IRQ_SRC_MASK);

    // Reset request is stretched so the chip reset sees a clean pulse.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            rst_cnt_q <= '0;
        end else if (wd_reset_evt || sw_reset_evt) begin
            rst_cnt_q <= RST_HOLD;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - 6'h01;
        end
    end

    assign sys_reset_req = (rst_cnt_q != '0);

    always_comb begin
        rd_mux = '0;
        unique case (1'b1)
            hit(paddr, wdit_pkg::OFS_CTRL): rd_mux[7:0] = ctrl_q;
            hit(paddr, wdit_pkg::OFS_RELOAD): rd_mux[7:0] = reload_q;
            hit(paddr, wdit_pkg::OFS_COUNT): rd_mux[7:0] = count_q;
            hit(paddr, wdit_pkg::OFS_STATUS): begin
                rd_mux[wdit_pkg::STAT_W-1:0] = status_q;
            end
            hit(paddr, wdit_pkg::OFS_MASK): begin
                rd_mux[wdit_pkg::STAT_W-1:0] = mask_q;
            end
            default: rd_mux = '0;
        endcase
    end

    // Read data is registered at the access edge and held until the next.
    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            prdata_q <= '0;
        end else if (rd_en) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (soft_reset_request) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // Data and error are combinational in the access phase for zero wait.
    assign prdata = rd_en ? rd_mux : prdata_q;
    assign pslverr = (access && !addr_ok) || pslverr_q;
endmodule : wdit_top
